// ---- hdl/ulpim_pkg.sv ----
// Purpose: Shared constants for the ULPI mode pin-map and termination block.
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses.
// Notes: Every offset and field position, and the control register reset value, used by the logic lives here.
package ulpim_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ULPIM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] ULPIM_ADDR_INT_EN = 8'h04;
   localparam logic [7:0] ULPIM_ADDR_INT_LATCH = 8'h08;
   localparam logic [7:0] ULPIM_ADDR_STATUS = 8'h0c;

   // ****************************************************************
   // Control register field positions
   // ****************************************************************
   localparam int ULPIM_CTRL_XCVR_LSB = 0;
   localparam int ULPIM_CTRL_TERM = 2;
   localparam int ULPIM_CTRL_OPMODE_LSB = 3;
   localparam int ULPIM_CTRL_DP_PD = 5;
   localparam int ULPIM_CTRL_DM_PD = 6;
   localparam int ULPIM_CTRL_SERIAL = 7;
   localparam int ULPIM_CTRL_KEEP_CLK = 8;
   localparam int ULPIM_CTRL_ENTER_LP = 9;

   // Power-up setting: XCVRSELECT 01b, TERMSELECT 0b, OPMODE 00b, both pull-downs on.
   localparam logic [8:0] ULPIM_CTRL_RESET = 9'h061;

   // ****************************************************************
   // Status register field positions
   // ****************************************************************
   localparam int ULPIM_STAT_STATE_LSB = 0;
   localparam int ULPIM_STAT_RES_LSB = 3;
   localparam int ULPIM_STAT_LINE_LSB = 7;
   localparam int ULPIM_STAT_INT = 9;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   localparam logic [1:0] ULPIM_OPMODE_TRISTATE = 2'h1;
   localparam logic [1:0] ULPIM_XCVR_HS = 2'h0;
   localparam logic [1:0] ULPIM_RESP_OKAY = 2'h0;
   localparam logic [1:0] ULPIM_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ULPIM_ST_SYNC = 3'h1,
      ULPIM_ST_LOWPWR = 3'h2,
      ULPIM_ST_SERIAL = 3'h4
   } ulpim_state_t;

endpackage

// ---- hdl/ulpim_term_decode.sv ----
// Purpose: Decode the signalling-state bits into the four line-resistor enables.
// Assumes: Inputs are the programmed register fields, stable in the clock domain.
// Notes: Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module ulpim_term_decode (
   input wire logic [1:0] xcvrselect,
   input wire logic termselect,
   input wire logic [1:0] opmode,
   input wire logic dplus_pulldown_request,
   input wire logic dminus_pulldown_request,
   output logic dplus_pullup_enable,
   output logic dplus_pulldown_enable,
   output logic dminus_pulldown_enable,
   output logic highspeed_termination_enable
);
   import ulpim_pkg::*;

   logic live;

   // The tri-state code overrides every other field, so it gates all four enables.
   assign live = (opmode != ULPIM_OPMODE_TRISTATE);
   assign dplus_pullup_enable = live & termselect & ~dplus_pulldown_request;
   assign dplus_pulldown_enable = live & dplus_pulldown_request;
   assign dminus_pulldown_enable = live & dminus_pulldown_request;
   assign highspeed_termination_enable = live & (xcvrselect == ULPIM_XCVR_HS)
      & ~termselect;
endmodule

// ---- hdl/ulpim_mode_top.sv ----
// Purpose: PHY-side ULPI low-power and 3-pin serial pin mapping, interrupt pin,
//    wake-up event and line-resistor control, configured over AXI4-Lite.
// Assumes: One 100 MHz clock; synchronous active-low reset; pin and analog
//    inputs arrive asynchronously.
// Notes: Line-state and received serial data reach the data pins without a
//    register, so data_out is the one combinational output.
//
// Operation
// - Send wake status if interrupt change persists.
// - Low power: pins 0,1 carry raw line state.
// - Low power: pin 2 driven low.
// - Pin 3 is active-high interrupt in both modes.
// - Stop exits serial mode to normal bus.
// - Serial mode: pin 0 is link transmit enable.
// - Serial mode: pin 1 differential data, direction by enable.
// - Serial mode: pin 2 single-ended zero, direction by enable.
// - Tri-state opmode forces all resistor enables off.
// - Pull-up when termselect set and no DP pull-down.
// - DP pull-down follows its request bit.
// - DM pull-down follows its request bit.
// - HS terminations when high-speed and termselect clear.
// - Direction held high in low-power and serial modes.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ulpim_mode_top #(
   parameter int NUM_INT = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_in,
   output logic dir_out,
   input wire logic [3:0] data_in,
   output logic [3:0] data_out,
   output logic [3:0] data_oe_n,
   input wire logic [1:0] line_state,
   input wire logic rx_differential,
   input wire logic rx_se0,
   output logic tx_enable,
   output logic serial_differential_bit,
   output logic tx_se0,
   input wire logic [NUM_INT-1:0] int_source,
   output logic rxcmd_request,
   output logic output_clock_enable,
   output logic dplus_pullup_enable,
   output logic dplus_pulldown_enable,
   output logic dminus_pulldown_enable,
   output logic highspeed_termination_enable
);
   import ulpim_pkg::*;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [6+NUM_INT:0] meta_q;
   logic [6+NUM_INT:0] sync_q;
   logic stop_s;
   logic [3:0] data_s;
   logic [1:0] line_s;
   logic [NUM_INT-1:0] src_s;

   // Two flops each for stop, data pins, line state and sources; only sync_q is used by the logic.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {int_source, line_state, data_in, stop_in};
         sync_q <= meta_q;
      end
   end
   assign stop_s = sync_q[0];
   assign data_s = sync_q[4:1];
   assign line_s = sync_q[6:5];
   assign src_s = sync_q[6+NUM_INT:7];

   // ****************************************************************
   // Register state and AXI4-Lite slave
   // ****************************************************************
   logic [8:0] ctrl_q, ctrl_d;
   logic [NUM_INT-1:0] int_en_q, int_en_d;
   logic [NUM_INT-1:0] latch_q, latch_d;
   logic [NUM_INT-1:0] prev_q, prev_d;
   logic [NUM_INT-1:0] snap_q, snap_d;
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic enter_lp_d;
   ulpim_state_t state_q, state_d;
   logic dir_q, dir_d, rxcmd_q, rxcmd_d, clken_q, clken_d;
   logic [3:0] oe_n_q, oe_n_d;
   logic tx_en_q, tx_en_d, tx_dat_q, tx_dat_d, tx_se0_q, tx_se0_d;
   logic int_q, int_d;
   logic [3:0] res_q, res_d;
   logic [3:0] res_w;
   logic [31:0] status_w;

   // Read view of the block's own state.
   always_comb begin
      status_w = '0;
      status_w[ULPIM_STAT_STATE_LSB +: 3] = state_q;
      status_w[ULPIM_STAT_RES_LSB +: 4] = res_q;
      status_w[ULPIM_STAT_LINE_LSB +: 2] = line_s;
      status_w[ULPIM_STAT_INT] = int_q;
   end

   // Bus handshakes, register writes and interrupt latching.
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      int_en_d = int_en_q;
      enter_lp_d = 1'b0;
      prev_d = src_s;
      latch_d = latch_q;
      // Address and data are taken independently, in either order.
      if (s_axi_awvalid && awready_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_held_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // Write commits once both halves are held and no response is pending.
      if (aw_held_q && w_held_q && !bvalid_q) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = ULPIM_RESP_OKAY;
         case (awaddr_q)
            ULPIM_ADDR_CTRL: begin
               if (wstrb_q[0]) begin
                  ctrl_d[7:0] = wdata_q[7:0];
               end
               if (wstrb_q[1]) begin
                  ctrl_d[ULPIM_CTRL_KEEP_CLK] = wdata_q[ULPIM_CTRL_KEEP_CLK];
                  enter_lp_d = wdata_q[ULPIM_CTRL_ENTER_LP];
               end
            end
            ULPIM_ADDR_INT_EN: begin
               if (wstrb_q[0]) begin
                  int_en_d = wdata_q[NUM_INT-1:0];
               end
            end
            ULPIM_ADDR_INT_LATCH: begin
               if (wstrb_q[0]) begin
                  latch_d = latch_q & ~wdata_q[NUM_INT-1:0];
               end
            end
            ULPIM_ADDR_STATUS: begin
            end
            default: begin
               bresp_d = ULPIM_RESP_SLVERR;
            end
         endcase
      end
      // A new source edge wins over a clear in the same cycle.
      latch_d = latch_d | (src_s & ~prev_q);
      // Serial select drops when stop takes the bus back.
      if (state_q == ULPIM_ST_SERIAL && stop_s) begin
         ctrl_d[ULPIM_CTRL_SERIAL] = 1'b0;
      end
      // Read channel: one outstanding read, answered the cycle after acceptance.
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = ULPIM_RESP_OKAY;
         case (s_axi_araddr)
            ULPIM_ADDR_CTRL: rdata_d = {23'h000000, ctrl_q};
            ULPIM_ADDR_INT_EN: rdata_d = {{(32-NUM_INT){1'b0}}, int_en_q};
            ULPIM_ADDR_INT_LATCH: rdata_d = {{(32-NUM_INT){1'b0}}, latch_q};
            ULPIM_ADDR_STATUS: rdata_d = status_w;
            default: begin
               rdata_d = '0;
               rresp_d = ULPIM_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      awready_d = !aw_held_d;
      wready_d = !w_held_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= ULPIM_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= ULPIM_RESP_OKAY;
         rdata_q <= '0;
         ctrl_q <= ULPIM_CTRL_RESET;
         int_en_q <= '0;
         latch_q <= '0;
         prev_q <= '0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= (arready_d || (!arready_q && !rvalid_q && !rvalid_d));
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         int_en_q <= int_en_d;
         latch_q <= latch_d;
         prev_q <= prev_d;
      end
   end

   // ****************************************************************
   // Mode state machine and pin mapping
   // ****************************************************************
   ulpim_term_decode u_decode (
      .xcvrselect(ctrl_q[ULPIM_CTRL_XCVR_LSB +: 2]),
      .termselect(ctrl_q[ULPIM_CTRL_TERM]),
      .opmode(ctrl_q[ULPIM_CTRL_OPMODE_LSB +: 2]),
      .dplus_pulldown_request(ctrl_q[ULPIM_CTRL_DP_PD]),
      .dminus_pulldown_request(ctrl_q[ULPIM_CTRL_DM_PD]),
      .dplus_pullup_enable(res_w[0]),
      .dplus_pulldown_enable(res_w[1]),
      .dminus_pulldown_enable(res_w[2]),
      .highspeed_termination_enable(res_w[3])
   );

   // Mode transitions; the link is trusted to run the clock before waking.
   always_comb begin
      state_d = state_q;
      snap_d = snap_q;
      rxcmd_d = 1'b0;
      case (state_q)
         ULPIM_ST_SYNC: begin
            if (enter_lp_d) begin
               state_d = ULPIM_ST_LOWPWR;
               snap_d = src_s;
            end else if (ctrl_q[ULPIM_CTRL_SERIAL]) begin
               state_d = ULPIM_ST_SERIAL;
            end
         end
         ULPIM_ST_LOWPWR: begin
            // Wake by stop; report only changes that still differ from entry.
            if (stop_s) begin
               state_d = ULPIM_ST_SYNC;
               rxcmd_d = |((src_s ^ snap_q) & int_en_q);
            end
         end
         ULPIM_ST_SERIAL: begin
            if (stop_s) begin
               state_d = ULPIM_ST_SYNC;
            end
         end
         default: begin
            state_d = ULPIM_ST_SYNC;
         end
      endcase
      dir_d = (state_d != ULPIM_ST_SYNC);
      clken_d = (state_d == ULPIM_ST_SYNC)
         || ((state_d == ULPIM_ST_SERIAL) && ctrl_q[ULPIM_CTRL_KEEP_CLK]);
      int_d = |(latch_d & int_en_q);
      res_d = res_w;
      tx_en_d = (state_q == ULPIM_ST_SERIAL) && data_s[0];
      tx_dat_d = tx_en_d && data_s[1];
      tx_se0_d = tx_en_d && data_s[2];
      // Active-low enables; bit 0 stays released in serial mode as link input.
      case (state_d)
         ULPIM_ST_LOWPWR: oe_n_d = 4'h0;
         ULPIM_ST_SERIAL: oe_n_d = data_s[0] ? 4'h7 : 4'h1;
         default: oe_n_d = 4'hf;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ULPIM_ST_SYNC;
         snap_q <= '0;
         rxcmd_q <= 1'b0;
         dir_q <= 1'b0;
         clken_q <= 1'b1;
         int_q <= 1'b0;
         res_q <= '0;
         tx_en_q <= 1'b0;
         tx_dat_q <= 1'b0;
         tx_se0_q <= 1'b0;
         oe_n_q <= 4'hf;
      end else begin
         state_q <= state_d;
         snap_q <= snap_d;
         rxcmd_q <= rxcmd_d;
         dir_q <= dir_d;
         clken_q <= clken_d;
         int_q <= int_d;
         res_q <= res_d;
         tx_en_q <= tx_en_d;
         tx_dat_q <= tx_dat_d;
         tx_se0_q <= tx_se0_d;
         oe_n_q <= oe_n_d;
      end
   end

   // Received line values bypass every register so the link sees them at once.
   always_comb begin
      data_out = 4'h0;
      if (state_q == ULPIM_ST_LOWPWR) begin
         data_out = {int_q, 1'b0, line_state};
      end else if (state_q == ULPIM_ST_SERIAL) begin
         data_out = {int_q, rx_se0, rx_differential, 1'b0};
      end
   end

   assign data_oe_n = oe_n_q;
   assign dir_out = dir_q;
   assign rxcmd_request = rxcmd_q;
   assign output_clock_enable = clken_q;
   assign tx_enable = tx_en_q;
   assign serial_differential_bit = tx_dat_q;
   assign tx_se0 = tx_se0_q;
   assign dplus_pullup_enable = res_q[0];
   assign dplus_pulldown_enable = res_q[1];
   assign dminus_pulldown_enable = res_q[2];
   assign highspeed_termination_enable = res_q[3];
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
endmodule

// ---- dv/ulpim_mode_monitor.sv ----
// Purpose: Port-level checks for the ULPI mode pin-map block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Register contents are hidden here, so checks tie pins to pins.
`timescale 1ns/1ps
module ulpim_mode_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stop_in,
   input wire logic dir_out,
   input wire logic [3:0] data_out,
   input wire logic [3:0] data_oe_n,
   input wire logic [1:0] line_state,
   input wire logic rx_differential,
   input wire logic rx_se0,
   input wire logic rxcmd_request,
   input wire logic dplus_pullup_enable,
   input wire logic dplus_pulldown_enable,
   input wire logic highspeed_termination_enable
);
   // ********
   // Checks
   // ********
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Low power drives every pin, receiver bits pass straight through.
   a_lp_line_pass: assert property (
      dir_out && data_oe_n == 4'h0 |-> data_out[1:0] == line_state)
      else $error("line state not on pins");
   a_lp_pin_low: assert property (
      dir_out && data_oe_n == 4'h0 |-> !data_out[2])
      else $error("reserved pin not low");
   a_int_pin_driven: assert property (dir_out |-> !data_oe_n[3])
      else $error("interrupt pin not driven");
   a_serial_tx_input: assert property (data_oe_n == 4'h7 |-> dir_out)
      else $error("enable pin released outside serial");
   a_serial_rx_out: assert property (
      data_oe_n == 4'h1 |-> data_out[2:1] == {rx_se0, rx_differential})
      else $error("received serial bits not on pins");
   // Exit needs only one sampled cycle of stop; the sync chain gives a short fixed lag.
   a_stop_exit: assert property ($rose(stop_in) && dir_out |-> ##[1:4] !dir_out)
      else $error("stop did not end the mode");
   a_dir_holds: assert property (
      $fell(dir_out) |-> $past(stop_in, 2) || $past(stop_in, 3))
      else $error("direction dropped without stop");
   a_rxcmd_pulse: assert property (rxcmd_request |=> !rxcmd_request)
      else $error("wake status longer than one cycle");
   a_rxcmd_exit: assert property (
      rxcmd_request |-> !dir_out && ($past(dir_out) || $past(dir_out, 2)))
      else $error("wake status outside an exit");
   a_pu_not_hs: assert property (
      highspeed_termination_enable |-> !dplus_pullup_enable)
      else $error("pull-up with terminations");
   a_pu_not_pd: assert property (
      dplus_pullup_enable |-> !dplus_pulldown_enable)
      else $error("pull-up with pull-down");
   c_lowpower: cover property ($rose(dir_out) && data_oe_n == 4'h0);
   c_serial_tx: cover property (data_oe_n == 4'h7);
   c_rxcmd: cover property (rxcmd_request);
endmodule

bind ulpim_mode_top ulpim_mode_monitor i_ulpim_mode_monitor (.aclk, .aresetn, .stop_in,
   .dir_out, .data_out, .data_oe_n, .line_state, .rx_differential, .rx_se0,
   .rxcmd_request, .dplus_pullup_enable, .dplus_pulldown_enable,
   .highspeed_termination_enable);

// ---- dv/ulpim_link_model.sv ----
// Purpose: Link-side model driving stop and the data pins.
// Assumes: The bench asks for wake-up, serial mode and transmit bits.
// Notes: Pins that nobody drives toggle every cycle, like a floating bus.
`timescale 1ns/1ps
module ulpim_link_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wake_req,
   input wire logic serial,
   input wire logic [2:0] tx_bits,
   input wire logic dir_out,
   input wire logic [3:0] data_out,
   input wire logic [3:0] data_oe_n,
   output logic stop_in,
   output logic [3:0] data_in
);
   logic stop_q, stop_d, flip_q, flip_d;
   logic [3:0] link_oe, link_val;
   // Stop is held until direction drops; the reference clock never stops
   // here, so it always runs before a wake.
   always_comb begin
      stop_d = wake_req | (stop_q & dir_out);
      flip_d = ~flip_q;
   end
   always_ff @(posedge aclk) begin
      stop_q <= aresetn & stop_d;
      flip_q <= aresetn & flip_d;
   end
   // Sync mode drives low; serial drives enable, and data and SE0 while the
   // enable is high; low power drives nothing.
   assign link_oe = !dir_out ? 4'hf : serial ? {1'b0, {2{tx_bits[0]}}, 1'b1} : 4'h0;
   assign link_val = dir_out ? {1'b0, tx_bits} : 4'h0;
   // The device wins where it drives, then the link, else a moving level.
   assign data_in = (~data_oe_n & data_out) | (data_oe_n & link_oe & link_val)
      | (data_oe_n & ~link_oe & {4{flip_q}});
   assign stop_in = stop_q;
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the ULPI mode pin-map block.
// Assumes: Link model on the pins; AXI4-Lite master tasks live here.
// Notes: Resistor decode is table driven; mode walks are hand written.
`timescale 1ns/1ps
module testbench;
   import ulpim_pkg::*;
   // ********
   // Signals
   // ********
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf, int_source = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wake_req = 1'b0, serial = 1'b0;
   logic [1:0] line_state = 2'h0;
   logic rx_differential = 1'b0, rx_se0 = 1'b0;
   logic [2:0] tx_bits = 3'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic stop_in, dir_out, tx_enable, serial_differential_bit, tx_se0, rxcmd_request;
   logic output_clock_enable, dplus_pullup_enable, dplus_pulldown_enable;
   logic dminus_pulldown_enable, highspeed_termination_enable;
   logic [3:0] data_in, data_out, data_oe_n, res;
   int errors = 0, cmp_count = 0, rx_cnt = 0, cyc = 0;
   // Rows: control word beside {hsterm, dm_pd, dp_pd, dp_pu}.
   logic [12:0] rows [10] = '{{9'h070, 4'he}, {9'h065, 4'h6}, {9'h066, 4'h6},
      {9'h014, 4'h1}, {9'h000, 4'h8}, {9'h010, 4'h8}, {9'h045, 4'h5},
      {9'h040, 4'hc}, {9'h068, 4'h0}, {9'h04d, 4'h0}};
   assign res = {highspeed_termination_enable, dminus_pulldown_enable,
      dplus_pulldown_enable, dplus_pullup_enable};
   always #5 aclk = ~aclk;
   ulpim_mode_top #(.NUM_INT(4)) i_ulpim_mode_top (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .stop_in, .dir_out, .data_in, .data_out, .data_oe_n, .line_state,
      .rx_differential, .rx_se0, .tx_enable, .serial_differential_bit, .tx_se0,
      .int_source, .rxcmd_request, .output_clock_enable, .dplus_pullup_enable,
      .dplus_pulldown_enable, .dminus_pulldown_enable, .highspeed_termination_enable);
   ulpim_link_model i_ulpim_link_model (.aclk, .aresetn, .wake_req, .serial, .tx_bits,
      .dir_out, .data_out, .data_oe_n, .stop_in, .data_in);
   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask
   // Address and data are released each at its own handshake.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Bounded wait on direction, interrupt pin or transmit enable.
   task automatic wait_for(input int sel, input logic v);
      int n;
      logic s;
      n = 0;
      s = ~v;
      while (s !== v && n < 200) begin
         @(posedge aclk);
         #1;
         s = (sel == 0) ? dir_out : (sel == 1) ? data_out[3] : tx_enable;
         n++;
      end
      chk(s, v, "wait");
   endtask
   task automatic enter(input logic [31:0] c);
      logic [1:0] r;
      @(posedge aclk);
      serial <= c[7];
      axw(ULPIM_ADDR_CTRL, c, r);
      wait_for(0, 1'b1);
   endtask
   // Stop is held by the link model until direction drops.
   task automatic leave(input int exp_rx);
      int k0;
      k0 = rx_cnt;
      @(posedge aclk);
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      wait_for(0, 1'b0);
      repeat (3) @(posedge aclk);
      serial <= 1'b0;
      #1;
      chk(rx_cnt - k0, exp_rx, "wake status count");
      chk(data_oe_n, 4'hf, "bus released");
   endtask
   task automatic end_of_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Watchdog and wake-status pulse counter.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (rxcmd_request === 1'b1) rx_cnt++;
      if (cyc == 20000) begin
         errors++;
         $display("FAIL %0t timeout", $time);
         end_of_test();
      end
   end
   // ********
   // Sequence
   // ********
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      chk(res, 4'h6, "reset enables");
      axr(ULPIM_ADDR_CTRL, d, r);
      chk(d, 32'h061, "reset control");
      axr(8'h10, d, r);
      chk(r, ULPIM_RESP_SLVERR, "unmapped read");
      axw(8'h10, 32'hffffffff, r);
      chk(r, ULPIM_RESP_SLVERR, "unmapped write");
      s_axi_wstrb <= 4'h0;
      axw(ULPIM_ADDR_INT_EN, 32'hf, r);
      s_axi_wstrb <= 4'hf;
      axr(ULPIM_ADDR_INT_EN, d, r);
      chk(d, 32'h0, "strobe gating");
      for (int i = 0; i < 10; i++) begin
         axw(ULPIM_ADDR_CTRL, {23'h0, rows[i][12:4]}, r);
         repeat (2) @(posedge aclk);
         #1;
         chk(res, rows[i][3:0], "enables");
         axr(ULPIM_ADDR_STATUS, d, r);
         chk(d[6:3], rows[i][3:0], "status enables");
      end
      // Low power: pin map, masked and unmasked sources, two exits.
      axw(ULPIM_ADDR_CTRL, 32'h069, r);
      axw(ULPIM_ADDR_INT_EN, 32'h1, r);
      enter(32'h269);
      chk(data_oe_n, 4'h0, "low power drive");
      for (int k = 0; k < 4; k++) begin
         @(posedge aclk);
         line_state <= k[1:0];
         #1;
         chk(data_out[2:0], {1'b0, k[1:0]}, "low power pins");
      end
      @(posedge aclk);
      int_source <= 4'h2;
      repeat (8) @(posedge aclk);
      #1;
      chk(data_out[3], 1'b0, "masked source");
      @(posedge aclk);
      int_source <= 4'h3;
      wait_for(1, 1'b1);
      leave(1);
      enter(32'h269);
      @(posedge aclk);
      int_source <= 4'h2;
      repeat (8) @(posedge aclk);
      int_source <= 4'h3;
      leave(0);
      // Serial mode: receive, transmit, exit, then keep-clock entry.
      rx_differential <= 1'b1;
      enter(32'h0e9);
      repeat (4) @(posedge aclk);
      #1;
      chk(data_oe_n, 4'h1, "serial receive drive");
      chk(data_out[2:1], 2'h1, "serial receive pins");
      chk(output_clock_enable, 1'b0, "clock stopped");
      @(posedge aclk);
      rx_se0 <= 1'b1;
      #1;
      chk(data_out[2:1], 2'h3, "serial se0 pin");
      @(posedge aclk);
      tx_bits <= 3'h3;
      wait_for(2, 1'b1);
      repeat (3) @(posedge aclk);
      #1;
      chk({tx_se0, serial_differential_bit}, 2'h1, "transmit data");
      chk(data_oe_n, 4'h7, "transmit drive");
      @(posedge aclk);
      tx_bits <= 3'h5;
      repeat (5) @(posedge aclk);
      #1;
      chk({tx_se0, serial_differential_bit}, 2'h2, "transmit se0");
      @(posedge aclk);
      tx_bits <= 3'h0;
      leave(0);
      axr(ULPIM_ADDR_CTRL, d, r);
      chk(d[7], 1'b0, "serial bit cleared");
      enter(32'h1e9);
      chk(output_clock_enable, 1'b1, "clock kept");
      leave(0);
      end_of_test();
   end
endmodule
